// ==== design/aes3_cu_pkg.sv ====
/*
  Shared constants and carrier types for the channel-status and user-bit
  buffer manager. Assumes a 32-bit Avalon-MM register bus, word aligned.
*/
`default_nettype none
package aes3_cu_pkg;
  ////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int BLOCK_WORDS  = 24;   // 16-bit words per block
  localparam int BLOCK_FRAMES = 192;  // frames per block
  localparam int PTR_WORDS    = 48;   // staging words behind the port
  localparam int SYNC_STAGES  = 3;
  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX      = 8'h01;
  localparam logic [7:0] STATUS_IDX    = 8'h02;
  localparam logic [7:0] PTR_IDX       = 8'h03;
  localparam logic [7:0] PORT_IDX      = 8'h04;
  localparam logic [7:0] CS_BASE_IDX   = 8'h20;
  localparam logic [7:0] USER_BASE_IDX = 8'h40;
  // control fields
  localparam int CTRL_INHIBIT_BIT  = 0;
  localparam int CTRL_TWO_BYTE_BIT = 1;
  localparam int CTRL_SEL_B_BIT    = 2;
  localparam int CTRL_USER_BLK_BIT = 3;
  localparam int CTRL_XFER_IE_BIT  = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // status fields
  localparam int STATUS_XFER_BIT  = 0;
  localparam int STATUS_PRO_A_BIT = 1;
  localparam int STATUS_PRO_B_BIT = 2;
  // check byte generator
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam int PRO_BIT = 7;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // encoder request: frame strobe with its index, block boundary pulse
  typedef struct packed {
    logic       boundary;
    logic       frame_strobe;
    logic [7:0] frame_idx;
  } enc_req_t;

  // bits handed to the encoder for the strobed frame
  typedef struct packed {
    logic cs_a;
    logic cs_b;
    logic user_a;
    logic user_b;
  } enc_bits_t;
endpackage : aes3_cu_pkg
`default_nettype wire

// ==== design/aes3_cu_buffer_manager.sv ====
/*
  Channel-status and user-bit staging and transmit buffers with an
  Avalon-MM register slave, check byte generation and user-bit modes.
  Assumes the encoder runs on clk_sys and strobes each frame index.
*/
// Implementation choices: the Avalon-MM interface to the registers and the address map.
// Overview of operation
// - staging buffer readable and writable over bus
// - transfer raises interrupt when enabled
// - inhibit bit blocks staging-to-transmit transfers
// - professional block gets automatic check byte
// - hardware serial input also gets check byte
// - software mode reaches every channel status bit
// - 24 words, A upper byte, B lower
// - one control bit picks byte mode
// - one-byte read returns A or B
// - one-byte write stores byte in both
// - auto-incrementing port for whole-block transfers
// - two-byte read gives A then B
// - all-zero mode sends only zero user bits
// - block mode buffers host user data twice
// - user buffer always uses two-byte access
// - user word interleaves A7 B7 down B0
// - transmit buffer sole source, block loaded
// - byte MSB sent first, byte 0 base
// - full blocks of status and user held
`default_nettype none
module aes3_cu_buffer_manager
  import aes3_cu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire enc_req_t    enc_req,
  output enc_bits_t        enc_bits,
  input  wire logic        hw_mode_pin,
  input  wire logic        cs_serial_pin,
  output logic             xfer_irq
);
  ////////////////////////////////////////////////////////////////////////
  // storage: staging (e) and transmit (f) blocks
  logic [15:0] cs_e [BLOCK_WORDS];
  logic [15:0] cs_f [BLOCK_WORDS];
  logic [15:0] u_e  [BLOCK_WORDS];
  logic [15:0] u_f  [BLOCK_WORDS];
  logic [4:0]  ctrl_reg;
  logic        xfer_flag_reg;
  logic        xfer_done_reg;
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic [5:0]  ptr_reg;
  logic [5:0]  ptr_next;
  enc_bits_t   bits_reg;
  logic [SYNC_STAGES-1:0] hw_sync_reg;
  logic [SYNC_STAGES-1:0] ser_sync_reg;
  logic        hw_mode_reg;
  logic        ser_bit_reg;

  wire logic inhibit  = ctrl_reg[CTRL_INHIBIT_BIT];
  wire logic two_byte = ctrl_reg[CTRL_TWO_BYTE_BIT];
  wire logic sel_b    = ctrl_reg[CTRL_SEL_B_BIT];
  wire logic user_blk = ctrl_reg[CTRL_USER_BLK_BIT];
  wire logic xfer_ie  = ctrl_reg[CTRL_XFER_IE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, frozen while ce is low
  wire logic req    = read | write;
  wire logic take   = req & ack_reg & ce;
  wire logic [7:0] idx = address[9:2];
  assign waitrequest = req & ~(ack_reg & ce);
  assign readdata    = readdata_reg;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ack_reg <= 1'b0;
    else if (ce)
      ack_reg <= req & ~ack_reg;
  end

  // staging word selected by a direct window or by the port pointer
  logic [5:0] word;
  logic       word_hit;
  always_comb
  begin
    word     = 6'h00;
    word_hit = 1'b0;
    if (idx >= CS_BASE_IDX && idx < CS_BASE_IDX + 8'(BLOCK_WORDS))
    begin
      word     = 6'(idx - CS_BASE_IDX);
      word_hit = 1'b1;
    end
    else if (idx >= USER_BASE_IDX && idx < USER_BASE_IDX + 8'(BLOCK_WORDS))
    begin
      word     = 6'(idx - USER_BASE_IDX) + 6'(BLOCK_WORDS);
      word_hit = 1'b1;
    end
    else if (idx == PORT_IDX)
    begin
      word     = ptr_reg;
      word_hit = 1'b1;
    end
  end

  wire logic is_user = word >= 6'(BLOCK_WORDS);
  wire logic [4:0] slot = is_user ? 5'(word - 6'(BLOCK_WORDS)) : word[4:0];

  ////////////////////////////////////////////////////////////////////////
  // read data is captured in the wait cycle so it stands at the taking edge
  logic [15:0] rd_word;
  logic [31:0] rd_val;
  always_comb
  begin
    rd_word = is_user ? u_e[slot] : cs_e[slot];
    rd_val  = 32'h0000_0000;
    if (word_hit && (is_user || two_byte))
      rd_val = {16'h0000, rd_word};
    else if (word_hit)
      rd_val = {24'h00_0000, sel_b ? rd_word[7:0] : rd_word[15:8]};
    else if (idx == CTRL_IDX)
      rd_val = {27'h000_0000, ctrl_reg};
    else if (idx == STATUS_IDX)
      rd_val = {29'h0000_0000, cs_f[0][PRO_BIT], cs_f[0][8+PRO_BIT],
                xfer_flag_reg};
    else if (idx == PTR_IDX)
      rd_val = {26'h000_0000, ptr_reg};
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      readdata_reg <= 32'h0000_0000;
    else if (ce && read && !ack_reg)
      readdata_reg <= rd_val;
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and auto-incrementing port pointer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ctrl_reg <= CTRL_RESET;
    else if (take && write && idx == CTRL_IDX && byteenable[0])
      ctrl_reg <= writedata[4:0];
  end

  always_comb
  begin
    ptr_next = ptr_reg;
    // a write of it loads the pointer and any port access advances it; a read of it must leave it alone
    if (take && write && idx == PTR_IDX && byteenable[0])
      ptr_next = (writedata[5:0] < 6'(PTR_WORDS)) ? writedata[5:0] : 6'h00;
    else if (take && idx == PORT_IDX)
      ptr_next = (ptr_reg == 6'(PTR_WORDS - 1)) ? 6'h00 : ptr_reg + 6'h01;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ptr_reg <= 6'h00;
    else if (ce)
      ptr_reg <= ptr_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      hw_sync_reg  <= '0;
      ser_sync_reg <= '0;
      hw_mode_reg  <= 1'b0;
      ser_bit_reg  <= 1'b0;
    end
    else if (ce)
    begin
      hw_sync_reg  <= {hw_sync_reg[SYNC_STAGES-2:0], hw_mode_pin};
      ser_sync_reg <= {ser_sync_reg[SYNC_STAGES-2:0], cs_serial_pin};
      if (hw_sync_reg[1] == hw_sync_reg[2])
        hw_mode_reg <= hw_sync_reg[2];
      if (ser_sync_reg[1] == ser_sync_reg[2])
        ser_bit_reg <= ser_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // staging writes; the transfer only reads them, so held data survives
  wire logic bus_wr = take && write && word_hit;
  wire logic [2:0] fbit = 3'(7 - int'(enc_req.frame_idx[2:0]));
  wire logic [4:0] fword = enc_req.frame_idx[7:3];

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < BLOCK_WORDS; i++)
      begin
        cs_e[i] <= WORD_RESET;
        u_e[i]  <= WORD_RESET;
      end
    end
    else if (ce)
    begin
      if (bus_wr && is_user)
      begin
        if (byteenable[1]) u_e[slot][15:8] <= writedata[15:8];
        if (byteenable[0]) u_e[slot][7:0]  <= writedata[7:0];
      end
      else if (bus_wr && !hw_mode_reg && two_byte)
      begin
        if (byteenable[1]) cs_e[slot][15:8] <= writedata[15:8];
        if (byteenable[0]) cs_e[slot][7:0]  <= writedata[7:0];
      end
      else if (bus_wr && !hw_mode_reg && byteenable[0])
        cs_e[slot] <= {writedata[7:0], writedata[7:0]};
      // serial channel status in hardware mode, same bit for A and B
      if (hw_mode_reg && enc_req.frame_strobe &&
          enc_req.frame_idx < 8'(BLOCK_FRAMES))
      begin
        cs_e[fword][8+fbit] <= ser_bit_reg;
        cs_e[fword][fbit]   <= ser_bit_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // check byte over bytes 0..22, first transmitted bit first
  function automatic logic [7:0] check_byte(input logic [183:0] d);
    logic [7:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 183; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : check_byte

  logic [183:0] blk_a;
  logic [183:0] blk_b;
  always_comb
  begin
    for (int i = 0; i < BLOCK_WORDS - 1; i++)
    begin
      blk_a[8*(22-i) +: 8] = cs_e[i][15:8];
      blk_b[8*(22-i) +: 8] = cs_e[i][7:0];
    end
  end
  wire logic [7:0] crc_a = check_byte(blk_a);
  wire logic [7:0] crc_b = check_byte(blk_b);

  ////////////////////////////////////////////////////////////////////////
  // whole-block transfer at the boundary unless inhibited
  wire logic do_xfer = ce && enc_req.boundary && !inhibit;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < BLOCK_WORDS; i++)
      begin
        cs_f[i] <= WORD_RESET;
        u_f[i]  <= WORD_RESET;
      end
    end
    else if (do_xfer)
    begin
      for (int i = 0; i < BLOCK_WORDS; i++)
      begin
        cs_f[i] <= cs_e[i];
        u_f[i]  <= u_e[i];
      end
      if (cs_e[0][8+PRO_BIT])
        cs_f[BLOCK_WORDS-1][15:8] <= crc_a;
      if (cs_e[0][PRO_BIT])
        cs_f[BLOCK_WORDS-1][7:0] <= crc_b;
    end
  end

  // transfer event: sticky flag, write one to clear, set wins
  wire logic flag_clr = take && write && idx == STATUS_IDX &&
                        byteenable[0] && writedata[STATUS_XFER_BIT];
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      xfer_done_reg <= 1'b0;
      xfer_flag_reg <= 1'b0;
    end
    else if (ce)
    begin
      xfer_done_reg <= do_xfer;
      xfer_flag_reg <= do_xfer | (xfer_flag_reg & ~flag_clr);
    end
  end
  assign xfer_irq = xfer_flag_reg & xfer_ie;

  ////////////////////////////////////////////////////////////////////////
  // encoder bits: byte MSB first, user words interleave A then B
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      bits_reg <= '0;
    else if (ce && enc_req.frame_strobe)
    begin
      if (enc_req.frame_idx < 8'(BLOCK_FRAMES))
      begin
        bits_reg.cs_a   <= cs_f[fword][8+fbit];
        bits_reg.cs_b   <= cs_f[fword][fbit];
        bits_reg.user_a <= user_blk & u_f[fword][{fbit, 1'b1}];
        bits_reg.user_b <= user_blk & u_f[fword][{fbit, 1'b0}];
      end
      else
        bits_reg <= '0;
    end
  end
  assign enc_bits = bits_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_inhibit;
    (ce && enc_req.boundary && inhibit) |=> !xfer_done_reg;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("transfer while inhibited");

  property p_irq;
    (ce && enc_req.boundary && !inhibit && xfer_ie) |=> xfer_flag_reg && (xfer_irq || !xfer_ie);
  endproperty
  a_irq: assert property (p_irq) else $error("transfer did not raise irq");

  property p_atomic;
    xfer_done_reg |-> cs_f[3] == $past(cs_e[3]) && u_f[5] == $past(u_e[5]);
  endproperty
  a_atomic: assert property (p_atomic) else $error("transmit block not copied");

  property p_crc;
    (do_xfer && cs_e[0][8+PRO_BIT]) |=> cs_f[BLOCK_WORDS-1][15:8] == $past(crc_a);
  endproperty
  a_crc: assert property (p_crc) else $error("check byte missing");

  property p_zero_user;
    (ce && enc_req.frame_strobe && !user_blk) |=> !enc_bits.user_a && !enc_bits.user_b;
  endproperty
  a_zero_user: assert property (p_zero_user) else $error("user bit not zero");

  property p_one_byte_wr;
    (bus_wr && !is_user && !two_byte && !hw_mode_reg && byteenable[0])
      |=> cs_e[$past(slot)][15:8] == cs_e[$past(slot)][7:0];
  endproperty
  a_one_byte_wr: assert property (p_one_byte_wr) else $error("bytes differ");

  property p_two_byte_rd;
    (take && read && word_hit && two_byte && !hw_mode_reg)
      |-> readdata[15:0] == (is_user ? u_e[slot] : cs_e[slot]);
  endproperty
  a_two_byte_rd: assert property (p_two_byte_rd) else $error("read data wrong");

  property p_one_byte_rd;
    (take && read && word_hit && !is_user && !two_byte) |-> readdata[31:8] == 24'h00_0000;
  endproperty
  a_one_byte_rd: assert property (p_one_byte_rd) else $error("wide one-byte read");

  property p_port_inc;
    (take && idx == PORT_IDX && ptr_reg < 6'(PTR_WORDS - 1)) |=> ptr_reg == $past(ptr_reg) + 6'h01;
  endproperty
  a_port_inc: assert property (p_port_inc) else $error("pointer did not advance");

  property p_answer;
    (req && !ack_reg && ce) |=> !waitrequest || !ce;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  c_xfer:    cover property (xfer_done_reg && xfer_irq);
  c_blocked: cover property (ce && enc_req.boundary && inhibit);
  c_port:    cover property (take && idx == PORT_IDX && write);
  c_pro:     cover property (do_xfer && cs_e[0][8+PRO_BIT]);
endmodule : aes3_cu_buffer_manager
`default_nettype wire

// ==== bench/aes3_enc_model.sv ====
/*
  Encoder-side partner: strobes frame indices and block boundaries.
  Assumes one clock shared with the buffer manager.
*/
`default_nettype none
module aes3_enc_model
  import aes3_cu_pkg::*;
(
  input  wire logic clk_sys,
  output var enc_req_t enc_req
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // idle between requests; the boundary is a one-cycle pulse, frame strobes run for n cycles
  initial enc_req = '0;

  // boundary pulse, always issued well before the next frame 0 strobe
  task automatic send_boundary();
    @(posedge clk_sys);
    enc_req <= enc_req_t'(10'h200);
    @(posedge clk_sys);
    enc_req <= '0;
  endtask : send_boundary

  // back-to-back strobes, one frame index per cycle
  task automatic frames(input logic [7:0] first, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      enc_req <= {1'b0, 1'b1, first + 8'(i)};
    end
    @(posedge clk_sys);
    enc_req <= '0;
  endtask : frames
endmodule : aes3_enc_model
`default_nettype wire

// ==== bench/aes3_cu_buffer_manager_tb.sv ====
/*
  Self-checking bench for the buffer manager: Avalon master tasks,
  encoder partner, queued expectations. Assumes one 250 MHz clock.
*/
`default_nettype none
module aes3_cu_buffer_manager_tb
  import aes3_cu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic        ce = 1'b1;
  logic        hw_mode_pin = 1'b0;
  logic        cs_serial_pin = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest;
  enc_req_t    enc_req;
  enc_bits_t   enc_bits;
  logic        xfer_irq;
  logic [15:0] stg [24];
  logic [15:0] us [24];
  logic [31:0] exp_rd [$];
  logic [3:0]  exp_enc [$];
  logic        pend = 1'b0;
  logic [7:0]  lf = 8'h5F;
  int          n_mismatch = 0;
  int          compares = 0;
  ////////////////////////////////////////////////////////////
  always #2 clk_sys = ~clk_sys;

  // byte lanes stay all on; pins and clock enable come from the scenarios
  aes3_cu_buffer_manager dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .enc_req(enc_req), .enc_bits(enc_bits), .hw_mode_pin(hw_mode_pin),
    .cs_serial_pin(cs_serial_pin), .xfer_irq(xfer_irq));
  aes3_enc_model enc (.clk_sys(clk_sys), .enc_req(enc_req));

  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction : rnd

  // check byte over bytes 0..22 of one channel, msb first
  function automatic logic [7:0] crc(input int ch);
    logic [7:0] c;
    logic [7:0] d;
    c = CRC_INIT;
    for (int n = 0; n < 23; n++)
    begin
      d = ch ? stg[n][7:0] : stg[n][15:8];
      for (int b = 7; b >= 0; b--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[b]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    address   <= {i, 2'b00};
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    do
      @(posedge clk_sys);
    while (waitrequest !== 1'b0);
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, i, 32'h0);
  endtask : rd

  // note the bits due for the eight frames of word w, then strobe them
  task automatic play(input int w, input logic [15:0] cs, input logic [15:0] u);
    for (int k = 0; k < 8; k++)
      exp_enc.push_back({cs[15-k], cs[7-k], u[15-2*k], u[14-2*k]});
    enc.frames(8'(8 * w), 8);
  endtask : play

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // results are taken at the edge where they stand
  always @(posedge clk_sys)
  begin
    if (read && waitrequest === 1'b0 && exp_rd.size() > 0)
      chk("readdata", exp_rd.pop_front(), readdata);
    if (pend && exp_enc.size() > 0)
      chk("enc_bits", 32'(exp_enc.pop_front()), 32'(enc_bits));
    pend <= enc_req.frame_strobe;
  end

  // run is about 900 cycles; generous margin
  initial
  begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    logic [15:0] v;
    logic [15:0] old;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(CTRL_IDX, 32'h0);
    rd(STATUS_IDX, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0);
    $display("test reset and unmapped done");
    v = {rnd(), rnd()};
    wr(CS_BASE_IDX + 8'h03, {24'h0, v[7:0]});
    rd(CS_BASE_IDX + 8'h03, {24'h0, v[7:0]});
    wr(CTRL_IDX, 32'h2);
    rd(CS_BASE_IDX + 8'h03, {16'h0, v[7:0], v[7:0]});
    wr(CS_BASE_IDX + 8'h05, {16'h0, v});
    wr(CTRL_IDX, 32'h0);
    rd(CS_BASE_IDX + 8'h05, {24'h0, v[15:8]});
    wr(CTRL_IDX, 32'h4);
    rd(CS_BASE_IDX + 8'h05, {24'h0, v[7:0]});
    $display("test byte modes done");
    wr(CTRL_IDX, 32'h2);
    wr(PTR_IDX, 32'h0);
    for (int i = 0; i < 48; i++)
    begin
      v = {rnd(), rnd()};
      if (i < 24)
        stg[i] = (i == 0) ? (v & 16'h7F7F) : v;
      else
        us[i-24] = v;
      wr(PORT_IDX, {16'h0, (i < 24) ? stg[i] : us[i-24]});
    end
    rd(PORT_IDX, {16'h0, stg[0]});
    wr(PTR_IDX, 32'h3F);
    rd(PTR_IDX, 32'h0);
    wr(PTR_IDX, 32'h5);
    rd(PTR_IDX, 32'h5);
    rd(PTR_IDX, 32'h5);
    for (int i = 0; i < 24; i++)
    begin
      rd(CS_BASE_IDX + 8'(i), {16'h0, stg[i]});
      rd(USER_BASE_IDX + 8'(i), {16'h0, us[i]});
    end
    $display("test port and full block done");
    enc.send_boundary();
    #1 chk("xfer_irq", 32'h0, 32'(xfer_irq));
    rd(STATUS_IDX, 32'h1);
    wr(CTRL_IDX, 32'h12);
    #1 chk("xfer_irq", 32'h1, 32'(xfer_irq));
    wr(STATUS_IDX, 32'h1);
    #1 chk("xfer_irq", 32'h0, 32'(xfer_irq));
    for (int w = 0; w < 24; w++)
      play(w, stg[w], 16'h0);
    $display("test transfer done");
    wr(CTRL_IDX, 32'h13);
    old = stg[1];
    stg[1] = ~old;
    wr(CS_BASE_IDX + 8'h01, {16'h0, stg[1]});
    enc.send_boundary();
    #1 chk("xfer_irq", 32'h0, 32'(xfer_irq));
    rd(STATUS_IDX, 32'h0);
    play(1, old, 16'h0);
    wr(CTRL_IDX, 32'h12);
    enc.send_boundary();
    #1 chk("xfer_irq", 32'h1, 32'(xfer_irq));
    play(1, stg[1], 16'h0);
    wr(STATUS_IDX, 32'h1);
    // a boundary while the clock enable is low must not transfer
    ce <= 1'b0;
    enc.send_boundary();
    #1 chk("xfer_irq", 32'h0, 32'(xfer_irq));
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(STATUS_IDX, 32'h0);
    $display("test inhibit done");
    wr(CTRL_IDX, 32'hA);
    stg[0] = stg[0] | 16'h8080;
    wr(CS_BASE_IDX, {16'h0, stg[0]});
    enc.send_boundary();
    rd(STATUS_IDX, 32'h7);
    for (int w = 0; w < 24; w++)
      play(w, (w == 23) ? {crc(0), crc(1)} : stg[w], us[w]);
    wr(CTRL_IDX, 32'h8);
    rd(USER_BASE_IDX + 8'h03, {16'h0, us[3]});
    $display("test user block and check byte done");
    // serial channel status in hardware mode; channel status bus writes are refused meanwhile
    hw_mode_pin   <= 1'b1;
    cs_serial_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(CS_BASE_IDX + 8'h02, 32'h0);
    enc.frames(8'h00, 8);
    hw_mode_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    stg[0] = 16'hFFFF;
    rd(CS_BASE_IDX, 32'hFF);
    enc.send_boundary();
    play(23, {crc(0), crc(1)}, us[23]);
    $display("test hardware mode done");
    repeat (4) @(posedge clk_sys);
    end_sim();
  end
endmodule : aes3_cu_buffer_manager_tb
`default_nettype wire
